// file: sbtc_pkg.sv
`default_nettype none
package sbtc_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h2;
   localparam logic [2:0] ADDR_FLAG = 3'h3;
   localparam logic [2:0] ADDR_ENABLE = 3'h4;
   localparam logic [2:0] ADDR_COMPARE_LOW = 3'h5;
   localparam logic [2:0] ADDR_COMPARE_HIGH = 3'h6;
   localparam logic [2:0] ADDR_PORT_C = 3'h7;
   // Control register fields
   localparam int BIT_WIDE = 7;
   localparam int BIT_PRESCALE_HI = 5;
   localparam int BIT_PRESCALE_LO = 4;
   localparam int BIT_OSC_EN = 3;
   localparam int BIT_SYNC_N = 2;
   localparam int BIT_SOURCE = 1;
   localparam int BIT_RUN = 0;
   localparam logic [7:0] CONTROL_MASK = 8'hBF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // Compare mode code for the special event trigger
   localparam logic [3:0] MODE_SPECIAL_TRIGGER = 4'hB;
   // Instruction cycle is four oscillator clocks
   localparam int INSTR_DIV = 4;
   // Timer oscillator ceiling in kHz and system clock in kHz
   localparam int OSC_MAX_KHZ = 200;
   localparam int CLK_KHZ = 20000;
   localparam int OSC_MIN_PERIOD_CYC = CLK_KHZ / OSC_MAX_KHZ;
endpackage : sbtc_pkg
`default_nettype wire

// file: sbtc_prescaler.sv
`default_nettype none
module sbtc_prescaler (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic clear,
   input wire logic [1:0] ratio,
   input wire logic tick_in,
   // Result
   output logic tick_out
);
   logic [2:0] cnt_r;
   logic [2:0] limit;

   // Terminal count for 1:1, 1:2, 1:4, 1:8
   always_comb begin
      case (ratio)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end

   // Divide counter, cleared on low byte writes
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         cnt_r <= 3'h0;
      end else if (tick_in) begin
         cnt_r <= (cnt_r >= limit) ? 3'h0 : cnt_r + 3'h1;
      end
   end

   assign tick_out = tick_in && !clear && (cnt_r >= limit); // see [RULE_02]

   AST_PRESCALE_CLEAR: assert property (@(posedge clk) disable iff (reset) // see [RULE_19]
      clear |=> cnt_r == 3'h0) else $error("prescaler not cleared");
endmodule : sbtc_prescaler
`default_nettype wire

// file: sbtc_timer.sv
// Behaviour
// [RULE_01] Wide bit selects atomic 16-bit access
// [RULE_02] Prescale field divides by 1,2,4,8
// [RULE_03] Oscillator enable powers timer oscillator
// [RULE_04] Sync select matters only for external
// [RULE_05] Source bit: external pin or Fosc/4
// [RULE_06] Run bit starts and stops counting
// [RULE_07] Count per instruction cycle or edge
// [RULE_08] Oscillator on forces pins input, reads zero
// [RULE_09] Count wraps, overflow sets flag
// [RULE_10] Interrupt only when enable set
// [RULE_11] Compare trigger mode 1011 clears count
// [RULE_12] Trigger reset never sets overflow flag
// [RULE_13] Software avoids triggers in async mode
// [RULE_14] Software write beats unit one trigger
// [RULE_15] Compare pair sets the period
// [RULE_16] Low read copies high into buffer
// [RULE_17] Low write loads high from buffer
// [RULE_18] Wide mode hides live high byte
// [RULE_19] Only low writes clear prescaler
// [RULE_20] Control bit six reads zero
// [RULE_21] Unit two trigger starts conversion
// [RULE_22] Oscillator runs in sleep, to 200 kHz
// [RULE_23] Narrow mode high address is live
// [RULE_24] Synced edges pass two flip-flops
//
// Chosen here: strobed register access and the register addresses.
`default_nettype none
module sbtc_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Pins
   input wire logic osc_input_pin,
   input wire logic external_count_pin,
   input wire logic [1:0] port_c_direction,
   input wire logic [1:0] port_c_pin_level,
   output logic [1:0] port_c_pin_input_only,
   output logic osc_amp_enable,
   // Compare units
   input wire logic [3:0] compare_mode_field_one,
   input wire logic [3:0] compare_mode_field_two,
   input wire logic adc_enabled,
   output logic adc_start,
   // Interrupt request
   output logic overflow_irq
);
   logic [7:0] control_r;
   logic [15:0] count_r;
   logic [7:0] high_buffer_r;
   logic overflow_flag_r;
   logic overflow_irq_enable_r;
   logic [15:0] compare_value_pair_r;
   logic sync1_r, sync2_r, sync_prev_r, raw_prev_r;
   logic instr_tick;
   logic [1:0] div_r;
   logic ext_raw, ext_edge, count_tick, pre_tick;
   logic wide, low_write, low_read, high_write;
   logic match, trig_one, trig_two, adc_start_r;
   logic [7:0] rdata_r;

   assign wide = control_r[sbtc_pkg::BIT_WIDE];
   assign low_write = reg_write && reg_addr == sbtc_pkg::ADDR_COUNT_LOW;
   assign low_read = reg_read && reg_addr == sbtc_pkg::ADDR_COUNT_LOW;
   assign high_write = reg_write && reg_addr == sbtc_pkg::ADDR_COUNT_HIGH;

   // Control register
   always_ff @(posedge clk) begin
      if (reset) begin
         control_r <= sbtc_pkg::CONTROL_RESET;
      end else if (reg_write && reg_addr == sbtc_pkg::ADDR_CONTROL) begin
         control_r <= reg_wdata & sbtc_pkg::CONTROL_MASK; // see [RULE_20]
      end
   end

   // Oscillator amplifier and pin direction override
   assign osc_amp_enable = control_r[sbtc_pkg::BIT_OSC_EN]; // see [RULE_03] see [RULE_22]
   assign port_c_pin_input_only = {2{control_r[sbtc_pkg::BIT_OSC_EN]}}; // see [RULE_08]

   // Instruction clock divider
   always_ff @(posedge clk) begin
      if (reset) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   assign instr_tick = div_r == 2'(sbtc_pkg::INSTR_DIV - 1);

   // External source: oscillator input when enabled, else count pin
   assign ext_raw = control_r[sbtc_pkg::BIT_OSC_EN] ? osc_input_pin : external_count_pin;

   // Two-stage synchroniser and edge history
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync_prev_r <= 1'b0;
         raw_prev_r <= 1'b0;
      end else begin
         sync1_r <= ext_raw; // see [RULE_24]
         sync2_r <= sync1_r;
         sync_prev_r <= sync2_r;
         raw_prev_r <= ext_raw;
      end
   end

   // Rising edge, synchronised or taken straight from the pin
   always_comb begin
      if (control_r[sbtc_pkg::BIT_SYNC_N]) begin
         ext_edge = ext_raw && !raw_prev_r; // see [RULE_04]
      end else begin
         ext_edge = sync2_r && !sync_prev_r; // see [RULE_24]
      end
   end

   // Source select and run gate
   assign count_tick = control_r[sbtc_pkg::BIT_RUN] &&
      (control_r[sbtc_pkg::BIT_SOURCE] ? ext_edge : instr_tick); // see [RULE_05] see [RULE_06] see [RULE_07]

   // Prescaler
   sbtc_prescaler u_prescaler (
      .clk(clk),
      .reset(reset),
      .clear(low_write), // see [RULE_19]
      .ratio(control_r[sbtc_pkg::BIT_PRESCALE_HI:sbtc_pkg::BIT_PRESCALE_LO]),
      .tick_in(count_tick),
      .tick_out(pre_tick)
   );

   // Compare value pair, written by software
   always_ff @(posedge clk) begin
      if (reset) begin
         compare_value_pair_r <= 16'hFFFF;
      end else if (reg_write && reg_addr == sbtc_pkg::ADDR_COMPARE_LOW) begin
         compare_value_pair_r[7:0] <= reg_wdata;
      end else if (reg_write && reg_addr == sbtc_pkg::ADDR_COMPARE_HIGH) begin
         compare_value_pair_r[15:8] <= reg_wdata;
      end
   end

   // Special event triggers on compare match
   assign match = count_r == compare_value_pair_r; // see [RULE_15]
   assign trig_one = match && compare_mode_field_one == sbtc_pkg::MODE_SPECIAL_TRIGGER; // see [RULE_11]
   assign trig_two = match && compare_mode_field_two == sbtc_pkg::MODE_SPECIAL_TRIGGER;

   // Conversion start from unit two
   always_ff @(posedge clk) begin
      if (reset) begin
         adc_start_r <= 1'b0;
      end else begin
         adc_start_r <= trig_two && adc_enabled; // see [RULE_21]
      end
   end
   assign adc_start = adc_start_r;

   // Count register: write beats trigger, trigger beats increment
   always_ff @(posedge clk) begin
      if (reset) begin
         count_r <= 16'h0000;
      end else if (low_write) begin
         count_r[7:0] <= reg_wdata;
         if (wide) begin
            count_r[15:8] <= high_buffer_r; // see [RULE_17] see [RULE_14]
         end
      end else if (high_write && !wide) begin
         count_r[15:8] <= reg_wdata; // see [RULE_23]
      end else if (trig_one || trig_two) begin
         count_r <= 16'h0000; // see [RULE_11]
      end else if (pre_tick) begin
         count_r <= count_r + 16'h0001; // see [RULE_09]
      end
   end

   // High byte buffer used in wide mode
   always_ff @(posedge clk) begin
      if (reset) begin
         high_buffer_r <= 8'h00;
      end else if (wide && high_write) begin
         high_buffer_r <= reg_wdata; // see [RULE_18]
      end else if (wide && low_read) begin
         high_buffer_r <= count_r[15:8]; // see [RULE_16] see [RULE_01]
      end
   end

   // Overflow flag: set wins over software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         overflow_flag_r <= 1'b0;
      end else if (pre_tick && count_r == 16'hFFFF && !low_write && !trig_one && !trig_two &&
                   !(high_write && !wide)) begin
         overflow_flag_r <= 1'b1; // see [RULE_09] see [RULE_12]
      end else if (reg_write && reg_addr == sbtc_pkg::ADDR_FLAG) begin
         overflow_flag_r <= reg_wdata[0];
      end
   end

   // Interrupt enable
   always_ff @(posedge clk) begin
      if (reset) begin
         overflow_irq_enable_r <= 1'b0;
      end else if (reg_write && reg_addr == sbtc_pkg::ADDR_ENABLE) begin
         overflow_irq_enable_r <= reg_wdata[0];
      end
   end
   assign overflow_irq = overflow_flag_r && overflow_irq_enable_r; // see [RULE_10]

   // Read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            sbtc_pkg::ADDR_CONTROL: rdata_r <= control_r;
            sbtc_pkg::ADDR_COUNT_LOW: rdata_r <= count_r[7:0];
            sbtc_pkg::ADDR_COUNT_HIGH: rdata_r <= wide ? high_buffer_r : count_r[15:8]; // see [RULE_18]
            sbtc_pkg::ADDR_FLAG: rdata_r <= {7'h00, overflow_flag_r};
            sbtc_pkg::ADDR_ENABLE: rdata_r <= {7'h00, overflow_irq_enable_r};
            sbtc_pkg::ADDR_COMPARE_LOW: rdata_r <= compare_value_pair_r[7:0];
            sbtc_pkg::ADDR_COMPARE_HIGH: rdata_r <= compare_value_pair_r[15:8];
            sbtc_pkg::ADDR_PORT_C: rdata_r <= {6'h00,
               port_c_pin_level & ~{2{control_r[sbtc_pkg::BIT_OSC_EN]}}}; // see [RULE_08]
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign reg_rdata = rdata_r;

   // Checks on the count path

   // Wrap to zero raises the flag
   AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (reset) // see [RULE_09]
      (pre_tick && count_r == 16'hFFFF && !reg_write && !match) |=>
      (count_r == 16'h0000 && overflow_flag_r))
      else $error("wrap missing");

   // Trigger clear leaves the flag low
   AST_TRIG_NO_FLAG: assert property (@(posedge clk) disable iff (reset) // see [RULE_12]
      (trig_one && !reg_write && !overflow_flag_r) |=>
      (count_r == 16'h0000 && !overflow_flag_r))
      else $error("trigger set flag");

   // Low byte write beats a unit one trigger
   AST_WRITE_WINS: assert property (@(posedge clk) disable iff (reset) // see [RULE_14]
      (low_write && trig_one) |=> count_r[7:0] == $past(reg_wdata))
      else $error("trigger beat write");

   // Stopped counter holds its value
   AST_STOPPED: assert property (@(posedge clk) disable iff (reset) // see [RULE_06]
      (!control_r[0] && !reg_write && !match) |=> $stable(count_r))
      else $error("count moved while stopped");

   // Run bit gates every count tick
   AST_RUN_GATE: assert property (@(posedge clk) disable iff (reset) // see [RULE_06]
      !control_r[sbtc_pkg::BIT_RUN] |-> !count_tick)
      else $error("tick while stopped");

   // Internal source ignores the sync bit
   AST_SYNC_IGNORED: assert property (@(posedge clk) disable iff (reset) // see [RULE_04]
      !control_r[sbtc_pkg::BIT_SOURCE] |->
      (count_tick == (control_r[sbtc_pkg::BIT_RUN] && instr_tick)))
      else $error("internal tick wrong");

   // External source counts external edges only
   AST_EXT_SOURCE: assert property (@(posedge clk) disable iff (reset) // see [RULE_05]
      (control_r[sbtc_pkg::BIT_SOURCE] && control_r[sbtc_pkg::BIT_RUN]) |->
      (count_tick == ext_edge))
      else $error("external tick wrong");

   // Internal ticks come once per four clocks
   AST_INTERNAL_RATE: assert property (@(posedge clk) disable iff (reset) // see [RULE_07]
      (count_tick && !control_r[1]) |=> !count_tick [*3])
      else $error("internal tick too fast");

   // Synchronised edge is two clocks behind the pin
   AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (reset) // see [RULE_24]
      (control_r[sbtc_pkg::BIT_SOURCE] && !control_r[sbtc_pkg::BIT_SYNC_N] && ext_edge) |->
      $past(ext_raw, 2))
      else $error("sync edge early");

   // Prescale 1:1 passes every tick
   AST_PRESCALE_BYPASS: assert property (@(posedge clk) disable iff (reset) // see [RULE_02]
      (control_r[sbtc_pkg::BIT_PRESCALE_HI:sbtc_pkg::BIT_PRESCALE_LO] == 2'h0 && !low_write) |->
      (pre_tick == count_tick))
      else $error("prescale bypass wrong");

   // Flag rises only on a wrap or a software write
   AST_FLAG_SOURCE: assert property (@(posedge clk) disable iff (reset) // see [RULE_09]
      $rose(overflow_flag_r) |-> ($past(count_r) == 16'hFFFF || $past(reg_write)))
      else $error("flag without wrap");

   // Request needs flag and enable
   AST_IRQ_GATE: assert property (@(posedge clk) disable iff (reset) // see [RULE_10]
      overflow_irq |-> (overflow_irq_enable_r && overflow_flag_r))
      else $error("irq without enable");

   // Checks on triggers and pins

   // Unit two trigger clears the count
   AST_TRIG_CLEAR: assert property (@(posedge clk) disable iff (reset) // see [RULE_11]
      (trig_two && !reg_write) |=> count_r == 16'h0000)
      else $error("trigger did not clear");

   // Unit two trigger starts a conversion when enabled
   AST_ADC_START: assert property (@(posedge clk) disable iff (reset) // see [RULE_21]
      (trig_two && adc_enabled) |=> adc_start)
      else $error("conversion not started");

   // Conversion start only after a unit two trigger
   AST_ADC_ONLY_TRIG: assert property (@(posedge clk) disable iff (reset) // see [RULE_21]
      adc_start |-> $past(trig_two))
      else $error("stray conversion start");

   // Oscillator on forces both pins to input
   AST_PIN_INPUT: assert property (@(posedge clk) disable iff (reset) // see [RULE_03]
      osc_amp_enable |-> port_c_pin_input_only == 2'b11)
      else $error("pins not forced input");

   // Port reads give zero while the oscillator runs
   AST_PORT_MASK: assert property (@(posedge clk) disable iff (reset) // see [RULE_08]
      ($past(reg_read) && $past(reg_addr) == sbtc_pkg::ADDR_PORT_C && $past(osc_amp_enable)) |->
      reg_rdata[1:0] == 2'b00)
      else $error("port pins not masked");

   // Checks on register access

   // Wide mode high write lands in the buffer
   AST_BUFFER_WRITE: assert property (@(posedge clk) disable iff (reset) // see [RULE_01]
      (wide && high_write) |=> high_buffer_r == $past(reg_wdata))
      else $error("buffer not written");

   // Low read copies the live high byte
   AST_BUFFER_COPY: assert property (@(posedge clk) disable iff (reset) // see [RULE_16]
      (wide && low_read && !high_write) |=> high_buffer_r == $past(count_r[15:8]))
      else $error("buffer not loaded");

   // Low write loads all sixteen bits at once
   AST_ATOMIC_LOAD: assert property (@(posedge clk) disable iff (reset) // see [RULE_17]
      (wide && low_write) |=> count_r == {$past(high_buffer_r), $past(reg_wdata)})
      else $error("atomic write failed");

   // Wide mode high reads come from the buffer
   AST_WIDE_HIGH_READ: assert property (@(posedge clk) disable iff (reset) // see [RULE_18]
      ($past(reg_read) && $past(reg_addr) == sbtc_pkg::ADDR_COUNT_HIGH && $past(wide)) |->
      reg_rdata == $past(high_buffer_r))
      else $error("live high byte visible");

   // Narrow mode high write reaches the count
   AST_NARROW_HIGH_WRITE: assert property (@(posedge clk) disable iff (reset) // see [RULE_23]
      (high_write && !wide) |=> count_r[15:8] == $past(reg_wdata))
      else $error("high byte not written");

   // Unimplemented control bit reads zero
   AST_BIT6_ZERO: assert property (@(posedge clk) disable iff (reset) // see [RULE_20]
      ($past(reg_read) && $past(reg_addr) == sbtc_pkg::ADDR_CONTROL) |-> !reg_rdata[6])
      else $error("bit six set");
endmodule : sbtc_timer
`default_nettype wire

// file: sbtc_ext_src.sv
`default_nettype none
// Far-side count source: crystal or pin driver, held low between bursts
module sbtc_ext_src (
   // Clock
   input wire logic clk,
   // Pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Half period in clocks keeps the rate under the oscillator ceiling
   localparam int HALF = 60;
   initial pin = 1'b0;
   // Rising edges on request, pin still outside bursts
   task automatic burst(input int n);
      repeat (n) begin
         repeat (HALF) @(posedge clk);
         pin <= 1'b1;
         repeat (HALF) @(posedge clk);
         pin <= 1'b0;
      end
   endtask
endmodule // sbtc_ext_src
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, reg_write, reg_read, adc_enabled, ext_pin, osc_amp, adc_start, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, got;
   logic [1:0] pin_level, input_only;
   logic [3:0] mode_one, mode_two;
   int n_fail, checked, n_adc;
   // Control, edge count, expected low byte
   logic [23:0] rows [6] = '{24'h03_1010, 24'h17_1008, 24'h23_1004, 24'h37_1002,
      24'h0B_1010, 24'h02_1000};
   sbtc_ext_src sbtc_ext_src_inst (.clk(clk), .pin(ext_pin));
   sbtc_timer sbtc_timer_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .osc_input_pin(ext_pin), .external_count_pin(ext_pin),
      .port_c_direction(2'b00), .port_c_pin_level(pin_level),
      .port_c_pin_input_only(input_only), .osc_amp_enable(osc_amp),
      .compare_mode_field_one(mode_one), .compare_mode_field_two(mode_two),
      .adc_enabled(adc_enabled), .adc_start(adc_start), .overflow_irq(irq));
   // Clock
   always #25 clk = ~clk;
   // Conversion start pulses
   always @(posedge clk) if (adc_start === 1'b1) n_adc <= n_adc + 1;
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 got = reg_rdata;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
      checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h out of range", $time, g);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      {clk, reg_write, reg_read, adc_enabled, reg_addr, reg_wdata} = '0;
      {mode_one, mode_two, n_fail, checked, n_adc} = '0;
      reset = 1'b1;
      pin_level = 2'b11;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      // Edge counting across prescale, sync, oscillator and run settings, external source only
      foreach (rows[i]) begin
         wr(sbtc_pkg::ADDR_CONTROL, rows[i][23:16] & 8'hFE);
         wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
         wr(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
         wr(sbtc_pkg::ADDR_CONTROL, rows[i][23:16]);
         sbtc_ext_src_inst.burst(rows[i][15:8]);
         repeat (8) @(posedge clk);
         wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
         rd(sbtc_pkg::ADDR_COUNT_LOW);
         chk8(got, rows[i][7:0]);
         rd(sbtc_pkg::ADDR_COUNT_HIGH);
         chk8(got, 8'h00);
      end
      // Mid-run reset, then unimplemented control bit
      wr(sbtc_pkg::ADDR_CONTROL, 8'h81);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(sbtc_pkg::ADDR_CONTROL);
      chk8(got, sbtc_pkg::CONTROL_RESET);
      wr(sbtc_pkg::ADDR_CONTROL, 8'hFE);
      rd(sbtc_pkg::ADDR_CONTROL);
      chk8(got, 8'hBE);
      // Oscillator on forces pins to input and masks port reads
      chk8({6'h00, input_only}, 8'h03);
      chk8({7'h00, osc_amp}, 8'h01);
      rd(sbtc_pkg::ADDR_PORT_C);
      chk8(got & 8'h03, 8'h00);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
      rd(sbtc_pkg::ADDR_PORT_C);
      chk8(got & 8'h03, 8'h03);
      chk8({6'h00, input_only, osc_amp}, 8'h00);
      // Internal source, one count per four clocks, sync bit ignored
      wr(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h05);
      repeat (400) @(posedge clk);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
      rd(sbtc_pkg::ADDR_COUNT_LOW);
      chk_rng(got, 8'd98, 8'd102);
      // Wrap from the top sets the flag, request follows the enable
      wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'hFF);
      wr(sbtc_pkg::ADDR_COUNT_LOW, 8'hFE);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h03);
      sbtc_ext_src_inst.burst(2);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
      rd(sbtc_pkg::ADDR_COUNT_HIGH);
      chk8(got, 8'h00);
      rd(sbtc_pkg::ADDR_FLAG);
      chk8(got & 8'h01, 8'h01);
      chk8({7'h00, irq}, 8'h00);
      wr(sbtc_pkg::ADDR_ENABLE, 8'h01);
      chk8({7'h00, irq}, 8'h01);
      wr(sbtc_pkg::ADDR_FLAG, 8'h00);
      chk8({7'h00, irq}, 8'h00);
      // Wide mode: buffered high byte
      wr(sbtc_pkg::ADDR_CONTROL, 8'h80);
      wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'h12);
      wr(sbtc_pkg::ADDR_COUNT_LOW, 8'h34);
      wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'h56);
      rd(sbtc_pkg::ADDR_COUNT_LOW);
      chk8(got, 8'h34);
      rd(sbtc_pkg::ADDR_COUNT_HIGH);
      chk8(got, 8'h12);
      // Buffer write leaves the prescaler alone
      wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(sbtc_pkg::ADDR_CONTROL, 8'hB3);
      sbtc_ext_src_inst.burst(5);
      wr(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      sbtc_ext_src_inst.burst(3);
      wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
      rd(sbtc_pkg::ADDR_COUNT_LOW);
      chk8(got, 8'h01);
      // Special trigger from each unit, synced mode only
      for (int u = 0; u < 2; u++) begin
         wr(sbtc_pkg::ADDR_COMPARE_HIGH, 8'h00);
         wr(sbtc_pkg::ADDR_COMPARE_LOW, 8'h03);
         wr(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
         adc_enabled <= 1'b1;
         mode_one <= (u == 0) ? sbtc_pkg::MODE_SPECIAL_TRIGGER : 4'h0;
         mode_two <= (u == 1) ? sbtc_pkg::MODE_SPECIAL_TRIGGER : 4'h0;
         n_adc = 0;
         wr(sbtc_pkg::ADDR_CONTROL, 8'h03);
         sbtc_ext_src_inst.burst(7);
         wr(sbtc_pkg::ADDR_CONTROL, 8'h00);
         rd(sbtc_pkg::ADDR_COUNT_LOW);
         chk8(got, 8'h01);
         rd(sbtc_pkg::ADDR_FLAG);
         chk8(got & 8'h01, 8'h00);
         chk8(8'(n_adc), (u == 1) ? 8'h02 : 8'h00);
      end
      give_verdict();
   end
endmodule // tb
`default_nettype wire
